/* File: scu_ctrl.sv */
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "scu_regs.svh"
// Contract
// (RULE1) Interrupt-on sets global interrupt enable
// (RULE2) Interrupt-off clears global interrupt enable
// (RULE3) Return from interrupt re-enables interrupts
// (RULE4) Full halt stops clocks and oscillator
// (RULE5) CPU halt gates core, oscillator runs
// (RULE6) Reset instruction equals hardware chip reset
// (RULE7) Watchdog kick restarts watchdog count only
// (RULE8) System control instructions keep all flags
// (RULE9) Unconditional branch group takes two cycles
// (RULE10) Skips take two cycles if taken
// (RULE11) All other instructions take one cycle
// (RULE12) Flag update set depends on class
// (RULE13) Bit memory addresses limited to 0x00-0x7F
// (RULE14) Halt resumes on wake or reset
module scu_ctrl (
   input wire logic MCLK,
   input wire logic RSTN,
   input scu_pkg::scu_apb_req_t APB_REQ,
   output scu_pkg::scu_apb_rsp_t APB_RSP,
   input wire logic INSTR_VALID,
   input scu_pkg::scu_instr_t INSTR,
   output logic INSTR_READY,
   output logic INSTR_DONE,
   output scu_pkg::scu_flags_t FLAG_WE,
   output logic [6:0] BIT_ADDR,
   output logic BIT_ADDR_ERR,
   input wire logic IRQ_PEND,
   output logic IRQ_TO_CORE,
   output logic GIE,
   input wire logic WAKE,
   output logic CORE_CLK_EN,
   output logic OSC_EN,
   output logic CHIP_RST_REQ,
   output logic WDT_RESTART
);
   import scu_pkg::*;

   typedef enum logic [3:0] {
      ST_RUN    = 4'h1,
      ST_SECOND = 4'h2,
      ST_FULL   = 4'h4,
      ST_CPU    = 4'h8
   } scu_state_t;

   scu_state_t state_q, state_d;
   logic wake_s1_q, wake_s2_q;
   logic gie_q;
   logic wake_en_q;
   logic swrst_q;
   logic badbit_q;
   logic reti_q;
   logic soft_rst_q;
   logic [31:0] cycles_q;
   logic ready_q;
   logic [31:0] rdata_q;
   logic err_q;
   scu_flags_t flag_we_q;
   logic [6:0] bit_addr_q;
   logic bit_err_q;
   logic done_q;
   logic core_clk_en_q, osc_en_q, rst_req_q, wdt_q;
   scu_flags_t dec_flags;
   logic [1:0] dec_cycles;
   logic dec_bit_ok;
   logic take;
   logic wake_ev;
   logic apb_acc, apb_wr, apb_rd;

   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
      reg_hit = (a == ofs);
   endfunction

   scu_decode u_dec (
      .instr(INSTR),
      .flag_we(dec_flags),
      .cycles(dec_cycles),
      .bit_ok(dec_bit_ok)
   );

   assign take = INSTR_VALID && (state_q == ST_RUN) && !soft_rst_q;
   assign INSTR_READY = (state_q == ST_RUN) && !soft_rst_q;
   assign wake_ev = wake_s2_q && wake_en_q;

   // Wake pin from outside the clock domain
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end else begin
         wake_s1_q <= WAKE;
         wake_s2_q <= wake_s1_q;
      end
   end

   // Soft reset held one cycle so state, reti, GIE, wake enable, reset cause and cycle registers see it
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         soft_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= take && (INSTR.op == SCU_OP_RESET); // (RULE6)
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN: begin
            if (take) begin
               if (INSTR.op == SCU_OP_FULL_HALT) begin
                  state_d = ST_FULL; // (RULE4)
               end else if (INSTR.op == SCU_OP_CPU_HALT) begin
                  state_d = ST_CPU; // (RULE5)
               end else if (dec_cycles == `SCU_CYC_TWO) begin
                  state_d = ST_SECOND; // (RULE9) (RULE10)
               end
            end
         end
         ST_SECOND: begin
            state_d = ST_RUN;
         end
         ST_FULL, ST_CPU: begin
            if (wake_ev) begin
               state_d = ST_RUN; // (RULE14)
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
      if (soft_rst_q) begin
         state_d = ST_RUN; // (RULE6) (RULE14)
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Remember reti until its second cycle completes
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         reti_q <= 1'b0;
      end else if (soft_rst_q) begin
         reti_q <= 1'b0;
      end else if (take) begin
         reti_q <= (INSTR.op == SCU_OP_RETI);
      end else if (state_q == ST_SECOND) begin
         reti_q <= 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         gie_q <= 1'b0;
      end else if (soft_rst_q) begin
         gie_q <= 1'b0; // (RULE6)
      end else if (take && INSTR.op == SCU_OP_INT_ON) begin
         gie_q <= 1'b1; // (RULE1)
      end else if (take && INSTR.op == SCU_OP_INT_OFF) begin
         gie_q <= 1'b0; // (RULE2)
      end else if (state_q == ST_SECOND && reti_q) begin
         gie_q <= 1'b1; // (RULE3)
      end
   end

   assign GIE = gie_q;
   assign IRQ_TO_CORE = gie_q && IRQ_PEND; // (RULE1) (RULE2)

   // Issue-time outputs: flag enables and bit address
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         flag_we_q <= '0;
         bit_addr_q <= '0;
         bit_err_q <= 1'b0;
      end else begin
         flag_we_q <= take ? dec_flags : '0; // (RULE8) (RULE12)
         bit_addr_q <= INSTR.bit_addr[`SCU_BIT_ADDR_W-1:0]; // (RULE13)
         bit_err_q <= take && !dec_bit_ok; // (RULE13)
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         done_q <= 1'b0;
      end else begin
         done_q <= (take && dec_cycles == `SCU_CYC_ONE) || (state_q == ST_SECOND); // (RULE9) (RULE10) (RULE11)
      end
   end

   // Clock gating and side pulses
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         core_clk_en_q <= 1'b1;
         osc_en_q <= 1'b1;
      end else begin
         core_clk_en_q <= (state_d == ST_RUN) || (state_d == ST_SECOND); // (RULE4) (RULE5)
         osc_en_q <= (state_d != ST_FULL); // (RULE4) (RULE5)
      end
   end

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_req_q <= 1'b0;
         wdt_q <= 1'b0;
      end else begin
         rst_req_q <= take && INSTR.op == SCU_OP_RESET; // (RULE6)
         wdt_q <= take && INSTR.op == SCU_OP_WDT_KICK; // (RULE7)
      end
   end

   assign FLAG_WE = flag_we_q;
   assign BIT_ADDR = bit_addr_q;
   assign BIT_ADDR_ERR = bit_err_q;
   assign INSTR_DONE = done_q;
   assign CORE_CLK_EN = core_clk_en_q;
   assign OSC_EN = osc_en_q;
   assign CHIP_RST_REQ = rst_req_q;
   assign WDT_RESTART = wdt_q;

   // APB slave: one wait state, read data from flops
   assign apb_acc = APB_REQ.psel && APB_REQ.penable && !ready_q;
   assign apb_wr = APB_REQ.psel && APB_REQ.penable && ready_q && APB_REQ.pwrite;
   assign apb_rd = apb_acc && !APB_REQ.pwrite;

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         ready_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= `SCU_APB_ZERO;
      end else begin
         ready_q <= apb_acc;
         if (apb_acc) begin
            err_q <= !(reg_hit(APB_REQ.paddr, `SCU_CTRL_OFS) || reg_hit(APB_REQ.paddr, `SCU_STATUS_OFS)
                       || reg_hit(APB_REQ.paddr, `SCU_CYCLES_OFS));
         end
         rdata_q <= `SCU_APB_ZERO;
         if (apb_rd && reg_hit(APB_REQ.paddr, `SCU_CTRL_OFS)) begin
            rdata_q[`SCU_CTRL_WAKE_EN] <= wake_en_q;
         end else if (apb_rd && reg_hit(APB_REQ.paddr, `SCU_STATUS_OFS)) begin
            rdata_q[`SCU_ST_GIE] <= gie_q;
            rdata_q[`SCU_ST_HALT_FULL] <= (state_q == ST_FULL);
            rdata_q[`SCU_ST_HALT_CPU] <= (state_q == ST_CPU);
            rdata_q[`SCU_ST_SWRST] <= swrst_q;
            rdata_q[`SCU_ST_BADBIT] <= badbit_q;
         end else if (apb_rd && reg_hit(APB_REQ.paddr, `SCU_CYCLES_OFS)) begin
            rdata_q <= cycles_q;
         end
      end
   end

   assign APB_RSP = '{prdata: rdata_q,
                      pready: ready_q,
                      pslverr: ready_q && err_q};

   // Soft reset returns wake enable to its reset value, as RSTN does
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         wake_en_q <= `SCU_CTRL_RST;
      end else if (soft_rst_q) begin
         wake_en_q <= `SCU_CTRL_RST; // (RULE6)
      end else if (apb_wr && reg_hit(APB_REQ.paddr, `SCU_CTRL_OFS)) begin
         wake_en_q <= APB_REQ.pwdata[`SCU_CTRL_WAKE_EN];
      end
   end

   // Sticky causes survive soft reset; set wins over write-one clear
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         swrst_q <= 1'b0;
         badbit_q <= 1'b0;
      end else begin
         if (soft_rst_q) begin
            swrst_q <= 1'b1;
         end else if (apb_wr && reg_hit(APB_REQ.paddr, `SCU_STATUS_OFS) && APB_REQ.pwdata[`SCU_ST_SWRST]) begin
            swrst_q <= 1'b0;
         end
         if (take && !dec_bit_ok) begin
            badbit_q <= 1'b1;
         end else if (apb_wr && reg_hit(APB_REQ.paddr, `SCU_STATUS_OFS) && APB_REQ.pwdata[`SCU_ST_BADBIT]) begin
            badbit_q <= 1'b0;
         end
      end
   end

   // Instruction cycle counter, written to reload
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         cycles_q <= `SCU_CYCLES_RST;
      end else if (soft_rst_q) begin
         cycles_q <= `SCU_CYCLES_RST;
      end else if (apb_wr && reg_hit(APB_REQ.paddr, `SCU_CYCLES_OFS)) begin
         cycles_q <= APB_REQ.pwdata;
      end else if (take || state_q == ST_SECOND) begin
         cycles_q <= cycles_q + 32'h1;
      end
   end

endmodule

/* File: scu_ctrl_checker.sv */
`timescale 1ns/1ps
module scu_ctrl_checker (
   input logic MCLK,
   input logic RSTN,
   input scu_pkg::scu_apb_rsp_t APB_RSP,
   input logic INSTR_VALID,
   input scu_pkg::scu_instr_t INSTR,
   input logic INSTR_READY,
   input logic INSTR_DONE,
   input scu_pkg::scu_flags_t FLAG_WE,
   input logic BIT_ADDR_ERR,
   input logic IRQ_PEND,
   input logic IRQ_TO_CORE,
   input logic GIE,
   input logic CORE_CLK_EN,
   input logic OSC_EN,
   input logic CHIP_RST_REQ,
   input logic WDT_RESTART
);
   import scu_pkg::*;
   logic tk;
   logic bit_op;
   scu_op_t op;
   assign tk = INSTR_VALID && INSTR_READY;
   assign op = INSTR.op;
   // Only bit forms are range checked
   assign bit_op = (op == SCU_OP_SKIP_BIT) || (op == SCU_OP_BITSET);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   a_gie_on: assert property (tk && op == SCU_OP_INT_ON |=> GIE)
      else $error("gie not set");
   a_gie_off: assert property (tk && op == SCU_OP_INT_OFF |=> !GIE)
      else $error("gie not cleared");
   a_irq_gate: assert property (IRQ_TO_CORE == (GIE && IRQ_PEND))
      else $error("irq gate wrong");
   a_reti_gie: assert property (tk && op == SCU_OP_RETI |=> !INSTR_READY ##1 GIE && INSTR_DONE)
      else $error("reti wrong");
   a_full_halt: assert property (tk && op == SCU_OP_FULL_HALT |=> !OSC_EN && !CORE_CLK_EN)
      else $error("full halt wrong");
   a_cpu_halt: assert property (tk && op == SCU_OP_CPU_HALT |=> OSC_EN && !CORE_CLK_EN)
      else $error("cpu halt wrong");
   a_soft_reset: assert property (tk && op == SCU_OP_RESET |=> CHIP_RST_REQ ##[0:2] !GIE)
      else $error("soft reset wrong");
   a_kick_only: assert property (tk && op == SCU_OP_WDT_KICK |=> WDT_RESTART && !CHIP_RST_REQ)
      else $error("kick wrong");
   a_sys_flags: assert property (tk && op >= SCU_OP_INT_ON |=> FLAG_WE == 4'h0)
      else $error("flags touched");
   a_two_cycle: assert property (tk && op == SCU_OP_BRANCH2 |=> !INSTR_DONE ##1 INSTR_DONE)
      else $error("branch timing");
   a_skip_taken: assert property (tk && op == SCU_OP_SKIP_ARITH && INSTR.skip_cond
      |=> !INSTR_DONE ##1 INSTR_DONE)
      else $error("skip timing");
   a_bit_range: assert property (tk && INSTR.bit_mem && bit_op && INSTR.bit_addr[7] |=> BIT_ADDR_ERR)
      else $error("bit range");
   cover property (tk && op == SCU_OP_RETI);
   cover property (tk && op == SCU_OP_CPU_HALT);
   cover property (APB_RSP.pready && APB_RSP.pslverr);
endmodule

/* File: scu_decode.sv */
`timescale 1ns/1ps
`include "scu_regs.svh"

module scu_decode (
   input scu_pkg::scu_instr_t instr,
   output scu_pkg::scu_flags_t flag_we,
   output logic [1:0] cycles,
   output logic bit_ok
);
   import scu_pkg::*;

   always_comb begin
      flag_we = '0;
      unique case (instr.op)
         SCU_OP_ARITH, SCU_OP_SKIP_ARITH: begin
            flag_we = '1; // (RULE12)
         end
         SCU_OP_SHIFT: begin
            flag_we.carry = 1'b1; // (RULE12)
         end
         SCU_OP_LOGIC: begin
            flag_we.zero = 1'b1; // (RULE12)
         end
         // System control, branches, bit ops keep every flag
         default: begin
            flag_we = '0; // (RULE8)
         end
      endcase
   end

   always_comb begin
      unique case (instr.op)
         SCU_OP_BRANCH2, SCU_OP_RETI: begin
            cycles = `SCU_CYC_TWO; // (RULE9)
         end
         SCU_OP_SKIP_ARITH, SCU_OP_SKIP_BIT: begin
            cycles = instr.skip_cond ? `SCU_CYC_TWO : `SCU_CYC_ONE; // (RULE10)
         end
         default: begin
            cycles = `SCU_CYC_ONE; // (RULE11)
         end
      endcase
   end

   // Only memory forms are limited; IO bit forms use their own space
   assign bit_ok = !(instr.bit_mem && (instr.op == SCU_OP_SKIP_BIT || instr.op == SCU_OP_BITSET))
                   || (instr.bit_addr <= `SCU_BIT_ADDR_MAX); // (RULE13)
endmodule

/* File: scu_pkg.sv */
package scu_pkg;

   // Instruction classes as seen by the control unit
   typedef enum logic [3:0] {
      SCU_OP_OTHER     = 4'h0,
      SCU_OP_ARITH     = 4'h1,
      SCU_OP_SHIFT     = 4'h2,
      SCU_OP_LOGIC     = 4'h3,
      SCU_OP_BRANCH2   = 4'h4,
      SCU_OP_RETI      = 4'h5,
      SCU_OP_SKIP_ARITH = 4'h6,
      SCU_OP_SKIP_BIT  = 4'h7,
      SCU_OP_BITSET    = 4'h8,
      SCU_OP_INT_ON    = 4'h9,
      SCU_OP_INT_OFF   = 4'ha,
      SCU_OP_FULL_HALT = 4'hb,
      SCU_OP_CPU_HALT  = 4'hc,
      SCU_OP_RESET     = 4'hd,
      SCU_OP_WDT_KICK  = 4'he
   } scu_op_t;

   typedef struct packed {
      scu_op_t op;
      logic skip_cond;
      logic bit_mem;
      logic [7:0] bit_addr;
   } scu_instr_t;

   typedef struct packed {
      logic zero;
      logic carry;
      logic half_carry_flag;
      logic overflow_flag;
   } scu_flags_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } scu_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } scu_apb_rsp_t;

endpackage

/* File: scu_regs.svh */
`ifndef SCU_REGS_SVH
`define SCU_REGS_SVH

// APB register byte offsets
`define SCU_CTRL_OFS 12'h000
`define SCU_STATUS_OFS 12'h004
`define SCU_CYCLES_OFS 12'h008
`define SCU_ADDR_W 12

// Control register fields
`define SCU_CTRL_WAKE_EN 0
`define SCU_CTRL_RST 1'h1

// Status register fields
`define SCU_ST_GIE 0
`define SCU_ST_HALT_FULL 1
`define SCU_ST_HALT_CPU 2
`define SCU_ST_SWRST 3
`define SCU_ST_BADBIT 4

// Cycle counts per instruction
`define SCU_CYC_ONE 2'h1
`define SCU_CYC_TWO 2'h2

// Bit-addressed data memory reach
`define SCU_BIT_ADDR_MAX 8'h7f
`define SCU_BIT_ADDR_W 7

`define SCU_CYCLES_RST 32'h0
`define SCU_APB_ZERO 32'h0

`endif

/* File: tb_cpu_system_control_and_timing.sv */
`timescale 1ns/1ps
module tb_cpu_system_control_and_timing;
   import scu_pkg::*;
   typedef struct {scu_op_t op; logic sc; logic [3:0] fl; int cy;} scu_row_t;
   logic clk = 0, rst_n = 0, iv = 0, irq = 1, wake = 0, ge = 0;
   scu_apb_req_t areq = '0;
   scu_apb_rsp_t arsp;
   scu_instr_t ins = '0;
   scu_flags_t fwe;
   logic [6:0] ba;
   logic ird, idn, berr, ito, gie, cclk, osc, crst, wdt, er;
   logic [31:0] rd;
   int n_errors = 0, checked = 0;
   // Flag enables are zero, carry, half carry, overflow from the top bit down
   scu_row_t rows[13] = '{'{SCU_OP_OTHER, 0, 4'h0, 1}, '{SCU_OP_ARITH, 0, 4'hf, 1},
      '{SCU_OP_SHIFT, 0, 4'h4, 1}, '{SCU_OP_LOGIC, 0, 4'h8, 1}, '{SCU_OP_BITSET, 0, 4'h0, 1},
      '{SCU_OP_BRANCH2, 0, 4'h0, 2}, '{SCU_OP_SKIP_ARITH, 1, 4'hf, 2}, '{SCU_OP_SKIP_ARITH, 0, 4'hf, 1},
      '{SCU_OP_SKIP_BIT, 1, 4'h0, 2}, '{SCU_OP_INT_ON, 0, 4'h0, 1}, '{SCU_OP_INT_OFF, 0, 4'h0, 1},
      '{SCU_OP_RETI, 0, 4'h0, 2}, '{SCU_OP_WDT_KICK, 0, 4'h0, 1}};
   always #25 clk = ~clk;
   scu_ctrl dut (.MCLK(clk), .RSTN(rst_n), .APB_REQ(areq), .APB_RSP(arsp), .INSTR_VALID(iv),
      .INSTR(ins), .INSTR_READY(ird), .INSTR_DONE(idn), .FLAG_WE(fwe), .BIT_ADDR(ba),
      .BIT_ADDR_ERR(berr), .IRQ_PEND(irq), .IRQ_TO_CORE(ito), .GIE(gie), .WAKE(wake),
      .CORE_CLK_EN(cclk), .OSC_EN(osc), .CHIP_RST_REQ(crst), .WDT_RESTART(wdt));
   task automatic give_verdict;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      areq <= '{a, 1'b1, 1'b0, w, d};
      @(posedge clk);
      areq.penable <= 1'b1;
      // Sampled at the rising edge, before the slave's registers move
      @(posedge clk);
      while (arsp.pready !== 1'b1 && n < 8) begin
         @(posedge clk);
         n++;
      end
      chk("pready", 1, arsp.pready);
      rd = arsp.prdata;
      er = arsp.pslverr;
      areq <= '0;
   endtask
   task automatic run(scu_op_t op, logic sc, logic [7:0] b, logic [3:0] fl, int cy);
      int n;
      n = 1;
      @(posedge clk);
      iv <= 1'b1;
      ins <= '{op, sc, 1'b1, b};
      @(posedge clk);
      iv <= 1'b0;
      if (op == SCU_OP_INT_ON || op == SCU_OP_RETI)
         ge = 1;
      if (op == SCU_OP_INT_OFF || op == SCU_OP_RESET)
         ge = 0;
      @(negedge clk);
      chk("flags", fl, fwe);
      chk("berr", b[7], berr);
      chk("badr", b[6:0], ba);
      chk("wdt", op == SCU_OP_WDT_KICK, wdt);
      chk("crst", op == SCU_OP_RESET, crst);
      while (cy > 0 && idn !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      if (cy > 0) begin
         chk("cyc", cy, n);
         chk("gie", ge, gie);
         chk("irq", ge & irq, ito);
      end
   endtask
   // Bounded by the longest plausible run, so a hang still reports
   initial begin
      #200000;
      n_errors++;
      give_verdict;
   end
   initial begin
      int k;
      k = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("r_gie", 0, gie);
      chk("r_run", 3'h7, {cclk, osc, ird});
      foreach (rows[i]) run(rows[i].op, rows[i].sc, 8'h00, rows[i].fl, rows[i].cy);
      run(SCU_OP_SKIP_BIT, 0, 8'h7f, 4'h0, 1);
      run(SCU_OP_SKIP_BIT, 0, 8'h80, 4'h0, 1);
      $display("rows done");
      apb(1, 12'h008, 0);
      run(SCU_OP_ARITH, 0, 8'h00, 4'hf, 1);
      run(SCU_OP_BRANCH2, 0, 8'h00, 4'h0, 2);
      apb(0, 12'h008, 0);
      chk("cycles", 3, rd);
      apb(0, 12'h0ff, 0);
      chk("slverr", 1, er);
      chk("bad_rd", 0, rd);
      $display("apb done");
      run(SCU_OP_CPU_HALT, 0, 8'h00, 4'h0, 1);
      chk("cpu_halt", 2'b01, {cclk, osc});
      @(posedge clk);
      wake <= 1'b1;
      while (cclk !== 1'b1 && k < 8) begin
         @(negedge clk);
         k++;
      end
      chk("wake", 1, cclk);
      @(posedge clk);
      wake <= 1'b0;
      // Wake disabled, so only a reset may end this halt
      apb(1, 12'h000, 0);
      run(SCU_OP_FULL_HALT, 0, 8'h00, 4'h0, 1);
      chk("full_halt", 2'b00, {cclk, osc});
      @(posedge clk);
      wake <= 1'b1;
      repeat (6) @(posedge clk);
      wake <= 1'b0;
      @(negedge clk);
      chk("no_wake", 0, cclk);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      ge = 0;
      @(negedge clk);
      chk("hw_rst", 2'b11, {cclk, osc});
      chk("hw_gie", 0, gie);
      run(SCU_OP_INT_ON, 0, 8'h00, 4'h0, 1);
      // Enable alone must not reach the core without a pending request
      @(posedge clk);
      irq <= 1'b0;
      @(negedge clk);
      chk("irq_off", 0, ito);
      @(posedge clk);
      irq <= 1'b1;
      apb(1, 12'h000, 0);
      run(SCU_OP_RESET, 0, 8'h00, 4'h0, 0);
      repeat (2) @(negedge clk);
      chk("sw_gie", 0, gie);
      apb(0, 12'h000, 0);
      chk("sw_ctrl", 1, rd[0]);
      apb(0, 12'h004, 0);
      chk("sw_flag", 1, rd[3]);
      $display("system ops done");
      give_verdict;
   end
endmodule
bind scu_ctrl scu_ctrl_checker chk_i (.MCLK(MCLK), .RSTN(RSTN), .APB_RSP(APB_RSP),
   .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .INSTR_READY(INSTR_READY), .INSTR_DONE(INSTR_DONE),
   .FLAG_WE(FLAG_WE), .BIT_ADDR_ERR(BIT_ADDR_ERR), .IRQ_PEND(IRQ_PEND), .IRQ_TO_CORE(IRQ_TO_CORE),
   .GIE(GIE), .CORE_CLK_EN(CORE_CLK_EN), .OSC_EN(OSC_EN), .CHIP_RST_REQ(CHIP_RST_REQ),
   .WDT_RESTART(WDT_RESTART));
